// [inc/fcs_pkg.sv]
// Constants, field layouts and carrier types of the flash checksum scanner.
package fcs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] FCS_IDX_CONTROL = 10'h000;
  localparam logic [9:0] FCS_IDX_CONFIG  = 10'h001;
  localparam logic [9:0] FCS_IDX_STATUS  = 10'h002;
  localparam int         FCS_IDX_LSB     = 2;
  localparam int         FCS_IDX_MSB     = 11;

  // Field positions.
  localparam int FCS_CTRL_RESET_BIT  = 7;
  localparam int FCS_CTRL_FATAL_INTERRUPT_ENABLE_BIT  = 1;
  localparam int FCS_CTRL_ENABLE_BIT = 0;
  localparam int FCS_CFG_MODE_LSB    = 4;
  localparam int FCS_CFG_SRC_LSB     = 0;
  localparam int FCS_STAT_OK_BIT     = 1;
  localparam int FCS_STAT_BUSY_BIT   = 0;

  // Reset values.
  localparam logic [7:0] FCS_CTRL_RESET_VAL = 8'h00;
  localparam logic [7:0] FCS_CFG_RESET_VAL  = 8'h00;
  localparam logic [7:0] FCS_STAT_RESET_VAL = 8'h02;

  // Access modes and section codes.
  localparam logic [1:0] FCS_MODE_PRIORITY = 2'h0;
  localparam logic [1:0] FCS_SRC_FLASH     = 2'h0;
  localparam logic [1:0] FCS_SRC_LOADER_AND_PROGRAM_SECTIONS   = 2'h1;
  localparam logic [1:0] FCS_SRC_BOOT      = 2'h2;

  // Timing in main clock cycles.
  localparam int         FCS_START_DELAY  = 3;
  localparam int         FCS_FETCH_PERIOD = 3;
  localparam logic [1:0] FCS_DLY_LOAD     = 2'(FCS_START_DELAY - 1);
  localparam logic [1:0] FCS_FETCH_LAST   = 2'(FCS_FETCH_PERIOD - 1);

  // Checksum.
  localparam logic [15:0] FCS_CRC_POLY = 16'h1021;
  localparam logic [15:0] FCS_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] FCS_CRC_GOOD = 16'h0000;

  // Bus encodings.
  localparam logic [1:0]  FCS_HTRANS_NONSEQ = 2'h2;
  localparam logic        FCS_HRESP_OKAY    = 1'b0;
  localparam logic [31:0] FCS_RDATA_ZERO    = 32'h0000_0000;

  localparam int FCS_FLASH_AW = 16;

  typedef enum logic [2:0] {
    FCS_IDLE  = 3'b001,
    FCS_DELAY = 3'b010,
    FCS_SCAN  = 3'b100
  } fcs_phase_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } fcs_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
  } fcs_ahb_rsp_t;

  typedef struct packed {
    logic                    rd;
    logic [FCS_FLASH_AW-1:0] addr;
  } fcs_flash_req_t;

  typedef struct packed {
    logic [FCS_FLASH_AW-1:0] boot_last;
    logic [FCS_FLASH_AW-1:0] app_last;
    logic [FCS_FLASH_AW-1:0] flash_last;
  } fcs_sections_t;

  typedef struct packed {
    logic       req;
    logic [1:0] mode;
    logic [1:0] section;
  } fcs_startup_t;

  typedef struct packed {
    fcs_phase_t              phase;
    logic                    enable;
    logic                    fatal_interrupt_enable;
    logic [1:0]              mode;
    logic [1:0]              section;
    logic                    ok;
    logic                    busy;
    logic                    nmi;
    logic                    rst_pend;
    logic [1:0]              dly;
    logic [1:0]              div;
    logic [FCS_FLASH_AW-1:0] addr;
    logic [FCS_FLASH_AW-1:0] last;
    logic [15:0]             crc;
    logic                    stall;
    fcs_flash_req_t          flash;
    logic                    wr_pend;
    logic                    rd_pend;
    logic                    hit;
    logic [9:0]              idx;
    fcs_ahb_rsp_t            bus;
  } fcs_state_t;

endpackage

// [design/fcs_scanner.sv]
// Flash checksum scanner: register slave, scan sequencer, CRC and fatal interrupt.
//
// Functional notes
// [R1] Reset strobe write resets enable, configuration and status one cycle later.
// [R2] With fatal enable low, reset strobe is taken even while busy.
// [R3] With fatal enable high, reset strobe is ignored while busy.
// [R4] Reset strobe never holds a stored one; it reads zero.
// [R5] With fatal enable set, each failed comparison raises the fatal interrupt.
// [R6] Fatal enable clears only on system reset, not strobe or zero write.
// [R7] Setting fatal enable takes effect only while not busy.
// [R8] After a fatal interrupt the control register ignores all writes.
// [R9] Writing enable one starts a check; bit stays one; rewrite restarts.
// [R10] Writing enable zero does nothing: bit kept, check continues.
// [R11] After a start-up scan the enable bit reads one.
// [R12] Configuration ignores writes while busy or after a fatal interrupt.
// [R13] Access mode field bits 5:4; zero is priority mode, others reserved.
// [R14] Software must rewrite a non-zero mode to zero after start-up scan.
// [R15] Section field bits 1:0: whole flash, loader and program, loader only.
// [R16] After a start-up scan the section field shows the checked section.
// [R17] Pass flag is status bit 1, resets to one, valid when not busy.
// [R18] Busy flag is status bit 0, high while a check is in progress.
// [R19] A check begins three cycles after the enable write.
// [R20] Priority mode fetches one 16-bit word every third cycle, processor stalled.
// [R21] CRC-16-CCITT, start 0xFFFF, byte 0 first, most significant bit first.
// [R22] Mismatch clears pass; with fatal enable, interrupt held until system reset.
// [R23] After the last word, busy clears and pass reflects the checksum match.
// [R24] Stall is high during a check and drops the cycle after busy clears.
module fcs_scanner (
  input  wire logic                  CORE_CLK,     // Main clock, 250 MHz.
  input  wire logic                  RESET,        // System reset, synchronous, active high.
  input  wire fcs_pkg::fcs_ahb_req_t AHB_IN,       // Bus address, control and write data.
  input  wire logic                  HREADY,       // Bus ready, same as our ready out.
  output      fcs_pkg::fcs_ahb_rsp_t AHB_OUT,      // Bus ready out, read data, response.
  output      fcs_pkg::fcs_flash_req_t FLASH_OUT,  // Flash word read strobe and address.
  input  wire logic [15:0]           FLASH_RDATA,  // Flash word, valid one cycle after strobe.
  input  wire fcs_pkg::fcs_sections_t SECTION_ENDS,// Word addresses of each section's last word.
  input  wire fcs_pkg::fcs_startup_t STARTUP_IN,   // Start-up scan request and its settings.
  output      logic                  CPU_STALL,    // Processor stall request.
  output      logic                  NMI_REQ       // Fatal interrupt request.
);
  import fcs_pkg::*;

  fcs_state_t q;
  fcs_state_t next_q;

  logic        ap_take;
  logic        wr_ctrl;
  logic        wr_cfg;
  logic [31:0] wdat;
  logic        rst_ok;
  logic        word_step;
  logic        last_word;
  logic [15:0] crc_word;
  logic        scan_fail;
  logic [7:0]  ctrl_byte;
  logic [7:0]  cfg_byte;
  logic [7:0]  stat_byte;

  // One byte through the shift register, most significant bit first.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ FCS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign ap_take = AHB_IN.hsel && (AHB_IN.htrans == FCS_HTRANS_NONSEQ) && HREADY;
  assign wdat    = AHB_IN.hwdata;
  assign wr_ctrl = q.wr_pend && q.hit && (q.idx == FCS_IDX_CONTROL) && !q.nmi; // [R8]
  assign wr_cfg  = q.wr_pend && q.hit && (q.idx == FCS_IDX_CONFIG)
                   && !q.busy && !q.nmi; // [R12]
  assign rst_ok  = !q.fatal_interrupt_enable || !q.busy; // [R2] [R3]

  // The flash stores little-endian words, so the low byte is byte 0 and goes first.
  assign crc_word  = crc_byte(crc_byte(q.crc, FLASH_RDATA[7:0]), FLASH_RDATA[15:8]); // [R21]
  assign word_step = (q.phase == FCS_SCAN) && (q.div == FCS_FETCH_LAST);
  assign last_word = (q.addr == q.last);
  // Running the stored checksum through the CRC leaves zero when the image matches.
  assign scan_fail = word_step && last_word && (crc_word != FCS_CRC_GOOD);

  always_comb begin
    ctrl_byte = FCS_CTRL_RESET_VAL;
    ctrl_byte[FCS_CTRL_FATAL_INTERRUPT_ENABLE_BIT]  = q.fatal_interrupt_enable;
    ctrl_byte[FCS_CTRL_ENABLE_BIT] = q.enable; // [R4]
    cfg_byte  = FCS_CFG_RESET_VAL;
    cfg_byte[FCS_CFG_MODE_LSB +: 2] = q.mode;
    cfg_byte[FCS_CFG_SRC_LSB +: 2]  = q.section;
    stat_byte = FCS_CTRL_RESET_VAL;
    stat_byte[FCS_STAT_OK_BIT]   = q.ok;   // [R17]
    stat_byte[FCS_STAT_BUSY_BIT] = q.busy; // [R18]
  end

  always_comb begin
    next_q          = q;
    next_q.flash.rd = 1'b0;
    next_q.rst_pend = 1'b0;
    next_q.wr_pend  = 1'b0;
    next_q.rd_pend  = 1'b0;

    // Address phase. Reads take one wait state so a write just before is seen; a reset strobe just before is not yet applied.
    if (ap_take) begin
      next_q.hit     = (AHB_IN.haddr[31:FCS_IDX_MSB+1] == '0)
                       && (AHB_IN.haddr[FCS_IDX_LSB-1:0] == '0);
      next_q.idx     = AHB_IN.haddr[FCS_IDX_MSB:FCS_IDX_LSB];
      next_q.wr_pend = AHB_IN.hwrite;
      if (!AHB_IN.hwrite) begin
        next_q.rd_pend       = 1'b1;
        next_q.bus.hreadyout = 1'b0;
      end
    end
    if (q.rd_pend) begin
      next_q.bus.hreadyout = 1'b1;
      if (!q.hit) begin
        next_q.bus.hrdata = FCS_RDATA_ZERO;
      end else if (q.idx == FCS_IDX_CONTROL) begin
        next_q.bus.hrdata = {24'h00_0000, ctrl_byte};
      end else if (q.idx == FCS_IDX_CONFIG) begin
        next_q.bus.hrdata = {24'h00_0000, cfg_byte};
      end else if (q.idx == FCS_IDX_STATUS) begin
        next_q.bus.hrdata = {24'h00_0000, stat_byte};
      end else begin
        next_q.bus.hrdata = FCS_RDATA_ZERO;
      end
    end

    // Scan sequencer.
    case (q.phase)
      FCS_IDLE: begin
        next_q.phase = FCS_IDLE;
      end
      FCS_DELAY: begin
        if (q.dly == 2'h0) begin
          next_q.phase = FCS_SCAN; // [R19]
          next_q.div   = 2'h0;
          next_q.addr  = '0;
          next_q.crc   = FCS_CRC_INIT; // [R21]
          if (q.section == FCS_SRC_BOOT) begin
            next_q.last = SECTION_ENDS.boot_last; // [R15]
          end else if (q.section == FCS_SRC_LOADER_AND_PROGRAM_SECTIONS) begin
            next_q.last = SECTION_ENDS.app_last;
          end else begin
            next_q.last = SECTION_ENDS.flash_last;
          end
        end else begin
          next_q.dly = q.dly - 2'h1;
        end
      end
      FCS_SCAN: begin
        // Only priority access is built; reserved mode codes scan the same way.
        if (q.div == 2'h0) begin
          next_q.flash.rd   = 1'b1; // [R20]
          next_q.flash.addr = q.addr;
          next_q.div        = 2'h1;
        end else if (q.div != FCS_FETCH_LAST) begin
          next_q.div = q.div + 2'h1;
        end else begin
          next_q.div = 2'h0;
          next_q.crc = crc_word;
          if (last_word) begin
            next_q.phase = FCS_IDLE; // [R23]
            next_q.busy  = 1'b0;
            next_q.ok    = !scan_fail;
            if (scan_fail && q.fatal_interrupt_enable) begin
              next_q.nmi = 1'b1; // [R5] [R22]
            end
          end else begin
            next_q.addr = q.addr + 1'b1;
          end
        end
      end
      default: begin
        next_q.phase = FCS_IDLE;
      end
    endcase

    // Start-up scan takes its mode and section from the start-up settings.
    if (STARTUP_IN.req && (q.phase == FCS_IDLE) && !q.nmi) begin
      next_q.mode    = STARTUP_IN.mode;    // [R14]
      next_q.section = STARTUP_IN.section; // [R16]
      next_q.enable  = 1'b1; // [R11]
      next_q.busy    = 1'b1;
      next_q.phase   = FCS_DELAY;
      next_q.dly     = FCS_DLY_LOAD;
    end

    if (wr_cfg) begin
      next_q.mode    = wdat[FCS_CFG_MODE_LSB +: 2]; // [R13]
      next_q.section = wdat[FCS_CFG_SRC_LSB +: 2];  // [R15]
    end

    if (wr_ctrl) begin
      if (wdat[FCS_CTRL_RESET_BIT] && rst_ok) begin
        next_q.rst_pend = 1'b1; // [R1] [R4]
      end else if (!wdat[FCS_CTRL_RESET_BIT]) begin
        if (wdat[FCS_CTRL_FATAL_INTERRUPT_ENABLE_BIT] && !q.busy) begin
          next_q.fatal_interrupt_enable = 1'b1; // [R6] [R7]
        end
        if (wdat[FCS_CTRL_ENABLE_BIT]) begin
          next_q.enable = 1'b1; // [R9] [R10]
          next_q.busy   = 1'b1; // [R18]
          next_q.phase  = FCS_DELAY;
          next_q.dly    = FCS_DLY_LOAD;
        end
      end
    end

    // The pending strobe wins over anything else this cycle; fatal enable survives it.
    if (q.rst_pend) begin
      next_q.enable  = 1'b0; // [R1]
      next_q.mode    = FCS_CFG_RESET_VAL[FCS_CFG_MODE_LSB +: 2];
      next_q.section = FCS_CFG_RESET_VAL[FCS_CFG_SRC_LSB +: 2];
      next_q.ok      = FCS_STAT_RESET_VAL[FCS_STAT_OK_BIT];
      next_q.busy    = FCS_STAT_RESET_VAL[FCS_STAT_BUSY_BIT];
      next_q.phase   = FCS_IDLE;
    end

    // A restart during a scan drops the stall at once, so the processor runs through the delay.
    next_q.stall = (q.phase == FCS_SCAN) && (next_q.phase != FCS_DELAY); // [R19] [R24]
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      q                <= '0;
      q.phase          <= FCS_IDLE;
      q.enable         <= FCS_CTRL_RESET_VAL[FCS_CTRL_ENABLE_BIT];
      q.fatal_interrupt_enable          <= FCS_CTRL_RESET_VAL[FCS_CTRL_FATAL_INTERRUPT_ENABLE_BIT]; // [R6]
      q.ok             <= FCS_STAT_RESET_VAL[FCS_STAT_OK_BIT];   // [R17]
      q.busy           <= FCS_STAT_RESET_VAL[FCS_STAT_BUSY_BIT];
      q.crc            <= FCS_CRC_INIT;
      q.bus.hreadyout  <= 1'b1;
      q.bus.hrdata     <= FCS_RDATA_ZERO;
      q.bus.hresp      <= FCS_HRESP_OKAY;
    end else begin
      q <= next_q;
    end
  end

  assign AHB_OUT   = q.bus;
  assign FLASH_OUT = q.flash;
  assign CPU_STALL = q.stall;
  assign NMI_REQ   = q.nmi;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_strobe_clears_regs: assert property ( // [R1]
    wr_ctrl && wdat[FCS_CTRL_RESET_BIT] && rst_ok
    |=> ##1 (!q.enable && !q.busy && q.ok && (q.mode == 2'h0) && (q.section == 2'h0)))
    else $error("reset strobe did not clear the registers");

  a_strobe_busy_block: assert property ( // [R3]
    wr_ctrl && q.fatal_interrupt_enable && q.busy |=> !q.rst_pend)
    else $error("reset strobe taken while busy with fatal enable set");

  a_strobe_idle_take: assert property ( // [R2]
    wr_ctrl && !q.fatal_interrupt_enable && wdat[FCS_CTRL_RESET_BIT] |=> q.rst_pend)
    else $error("reset strobe not taken with fatal enable clear");

  a_fatal_interrupt_enable_sticky: assert property ( // [R6]
    q.fatal_interrupt_enable |=> q.fatal_interrupt_enable)
    else $error("fatal enable cleared without system reset");

  a_fatal_interrupt_enable_busy_set: assert property ( // [R7]
    !q.fatal_interrupt_enable && q.busy && wr_ctrl |=> !q.fatal_interrupt_enable)
    else $error("fatal enable set while busy");

  a_nmi_held: assert property ( // [R22]
    NMI_REQ |=> NMI_REQ ##1 NMI_REQ)
    else $error("fatal interrupt request dropped");

  a_fail_raises_nmi: assert property ( // [R5]
    scan_fail && q.fatal_interrupt_enable && !q.rst_pend |=> (NMI_REQ && !q.ok && !q.busy))
    else $error("failed check did not raise the fatal interrupt");

  a_cfg_locked: assert property ( // [R12]
    q.wr_pend && (q.idx == FCS_IDX_CONFIG) && (q.busy || q.nmi) && !q.rst_pend
    && !STARTUP_IN.req |=> (q.mode == $past(q.mode)) && (q.section == $past(q.section)))
    else $error("configuration changed while locked");

  a_start_delay: assert property ( // [R19]
    wr_ctrl && !wdat[FCS_CTRL_RESET_BIT] && wdat[FCS_CTRL_ENABLE_BIT] && !q.rst_pend
    |=> (q.phase == FCS_DELAY && !CPU_STALL) [*3] ##1 (q.phase == FCS_SCAN))
    else $error("check did not begin three cycles after enable");

  a_fetch_spacing: assert property ( // [R20]
    FLASH_OUT.rd |-> CPU_STALL ##1 !FLASH_OUT.rd ##1 !FLASH_OUT.rd)
    else $error("flash fetch spacing or stall wrong");

  a_enable_zero_keep: assert property ( // [R10]
    q.enable && wr_ctrl && !wdat[FCS_CTRL_ENABLE_BIT] && !wdat[FCS_CTRL_RESET_BIT]
    && !q.rst_pend |=> q.enable)
    else $error("writing enable zero changed it");

  a_stall_release: assert property ( // [R24]
    (q.phase == FCS_SCAN) ##1 (q.phase == FCS_IDLE) |-> CPU_STALL ##1 !CPU_STALL)
    else $error("stall not released one cycle after completion");

  a_strobe_reads_zero: assert property ( // [R4]
    q.rd_pend && q.hit && (q.idx == FCS_IDX_CONTROL) |=> !AHB_OUT.hrdata[FCS_CTRL_RESET_BIT])
    else $error("reset strobe read back as one");

  a_nmi_ctrl_locked: assert property ( // [R8]
    q.nmi && q.wr_pend && q.hit && (q.idx == FCS_IDX_CONTROL)
    |=> (q.fatal_interrupt_enable == $past(q.fatal_interrupt_enable)) && (q.enable == $past(q.enable)) && !q.rst_pend)
    else $error("control register written after a fatal interrupt");

  a_enable_starts: assert property ( // [R9]
    wr_ctrl && !wdat[FCS_CTRL_RESET_BIT] && wdat[FCS_CTRL_ENABLE_BIT] && !q.rst_pend
    |=> q.enable && q.busy && (q.phase == FCS_DELAY))
    else $error("enable write did not start a check");

  a_enable_sticky: assert property ( // [R10]
    q.enable && !q.rst_pend |=> q.enable)
    else $error("enable cleared other than by the reset strobe");

  a_startup_section: assert property ( // [R16]
    STARTUP_IN.req && (q.phase == FCS_IDLE) && !q.nmi && !q.rst_pend && !wr_cfg
    |=> (q.section == $past(STARTUP_IN.section)) && (q.mode == $past(STARTUP_IN.mode)))
    else $error("start-up scan did not load its settings");

  a_startup_enable: assert property ( // [R11]
    STARTUP_IN.req && (q.phase == FCS_IDLE) && !q.nmi && !q.rst_pend |=> q.enable && q.busy)
    else $error("start-up scan left enable or busy low");

  a_cfg_readback: assert property ( // [R13]
    q.rd_pend && q.hit && (q.idx == FCS_IDX_CONFIG)
    |=> (AHB_OUT.hrdata[FCS_CFG_MODE_LSB +: 2] == $past(q.mode))
        && (AHB_OUT.hrdata[FCS_CFG_SRC_LSB +: 2] == $past(q.section)))
    else $error("configuration read back wrong");

  a_status_readback: assert property ( // [R17]
    q.rd_pend && q.hit && (q.idx == FCS_IDX_STATUS)
    |=> (AHB_OUT.hrdata[FCS_STAT_OK_BIT] == $past(q.ok))
        && (AHB_OUT.hrdata[FCS_STAT_BUSY_BIT] == $past(q.busy)))
    else $error("status read back wrong");

  a_section_boot: assert property ( // [R15]
    (q.phase == FCS_DELAY) && (q.dly == 2'h0) && (q.section == FCS_SRC_BOOT)
    |=> (q.last == SECTION_ENDS.boot_last))
    else $error("loader section end not selected");

  a_section_loader_and_program_sections: assert property ( // [R15]
    (q.phase == FCS_DELAY) && (q.dly == 2'h0) && (q.section == FCS_SRC_LOADER_AND_PROGRAM_SECTIONS)
    |=> (q.last == SECTION_ENDS.app_last))
    else $error("loader and program section end not selected");

  a_busy_tracks_phase: assert property ( // [R18]
    q.busy == (q.phase != FCS_IDLE))
    else $error("busy flag does not match the sequencer");

  a_delay_no_stall: assert property ( // [R19]
    (q.phase == FCS_DELAY) |-> !CPU_STALL)
    else $error("processor stalled during the start delay");

  a_scan_stalls: assert property ( // [R20]
    (q.phase == FCS_SCAN) && ($past(q.phase) == FCS_SCAN) |-> CPU_STALL)
    else $error("processor not stalled during a scan");

  a_fetch_order: assert property ( // [R20]
    FLASH_OUT.rd ##3 FLASH_OUT.rd |-> (FLASH_OUT.addr == $past(FLASH_OUT.addr, 3) + 16'h0001))
    else $error("flash words not fetched in address order");

  a_crc_seed: assert property ( // [R21]
    (q.phase == FCS_DELAY) && (q.dly == 2'h0) |=> (q.crc == FCS_CRC_INIT) && (q.addr == '0))
    else $error("checksum not seeded at scan start");

  a_pass_on_match: assert property ( // [R23]
    word_step && last_word && !scan_fail && !wr_ctrl |=> q.ok && !q.busy)
    else $error("matching check did not end with pass");

  a_fail_clears_pass: assert property ( // [R22]
    scan_fail && !q.rst_pend && !wr_ctrl |=> !q.ok && !q.busy)
    else $error("failed check did not clear pass");

  a_nmi_needs_enable: assert property ( // [R5]
    $rose(NMI_REQ) |-> q.fatal_interrupt_enable && !q.ok)
    else $error("fatal interrupt raised without its enable");

endmodule

// [testbench/fcs_flash_model.sv]
// Behavioural flash array that answers word reads for the checksum scanner.
module fcs_flash_model (
  input  wire logic                    CLK,    // Main clock.
  input  wire fcs_pkg::fcs_flash_req_t REQ,    // Read strobe and word address.
  output logic [15:0]                  RDATA   // Word, valid the cycle after the strobe.
);
  timeunit 1ns;
  timeprecision 100ps;
  import fcs_pkg::*;
  logic [15:0] mem [0:15];

  // Outside the valid cycle the lines toggle so a sample one cycle late never looks right.
  always @(posedge CLK) begin
    if (REQ.rd === 1'b1) begin
      RDATA <= mem[REQ.addr[3:0]];
    end else begin
      RDATA <= ~RDATA;
    end
  end
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the flash checksum scanner.
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fcs_pkg::*;
  localparam logic [31:0] A_CTRL = {20'h0_0000, FCS_IDX_CONTROL, 2'b00};
  localparam logic [31:0] A_CFG  = {20'h0_0000, FCS_IDX_CONFIG, 2'b00};
  localparam logic [31:0] A_STAT = {20'h0_0000, FCS_IDX_STATUS, 2'b00};
  logic           core_clk;
  logic           reset;
  fcs_ahb_req_t   ahb;
  fcs_ahb_rsp_t   rsp;
  fcs_flash_req_t freq;
  logic [15:0]    fdata;
  fcs_sections_t  ends;
  fcs_startup_t   boot;
  logic           stall;
  logic           nmi;
  logic           saw_stall;
  logic [31:0]    rd_val;
  int             mismatches;
  int             samples_checked;
  int             cyc;
  int             last_rd;

  fcs_scanner dut (.CORE_CLK(core_clk), .RESET(reset), .AHB_IN(ahb), .HREADY(rsp.hreadyout),
    .AHB_OUT(rsp), .FLASH_OUT(freq), .FLASH_RDATA(fdata), .SECTION_ENDS(ends),
    .STARTUP_IN(boot), .CPU_STALL(stall), .NMI_REQ(nmi));
  fcs_flash_model flash (.CLK(core_clk), .REQ(freq), .RDATA(fdata));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Fetches inside one scan must be exactly three cycles apart.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (stall === 1'b1) saw_stall <= 1'b1;
    if (freq.rd === 1'b1) begin
      if (freq.addr != 16'h0000) check("fetch gap", 8'(cyc - last_rd), 8'h03);
      last_rd <= cyc;
    end
  end

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    ahb.hsel <= 1'b1;
    ahb.htrans <= FCS_HTRANS_NONSEQ;
    ahb.haddr <= a;
    ahb.hwrite <= w;
    ahb.hsize <= 3'h2;
    do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
    ahb.hsel <= 1'b0;
    ahb.htrans <= 2'h0;
    ahb.hwdata <= d;
    do @(posedge core_clk); while (rsp.hreadyout !== 1'b1);
    rd_val = rsp.hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h00_0000, d});
  endtask

  task automatic expect_reg(input string what, input logic [31:0] a, input logic [7:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rd_val[7:0], exp);
    check("response", {7'h00, rsp.hresp}, 8'h00);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, A_STAT, 32'h0000_0000);
      n++;
    end while (rd_val[FCS_STAT_BUSY_BIT] !== 1'b0 && n < 200);
  endtask

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ b[k]) ? FCS_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  function automatic int last_of(input logic [1:0] s);
    if (s == FCS_SRC_BOOT) return int'(ends.boot_last);
    if (s == FCS_SRC_LOADER_AND_PROGRAM_SECTIONS) return int'(ends.app_last);
    return int'(ends.flash_last);
  endfunction

  // Random words with the checksum, or its inverse, in the section's last word.
  task automatic load(input int last, input bit good);
    logic [15:0] c;
    c = FCS_CRC_INIT;
    for (int i = 0; i < 16; i++) flash.mem[i] = 16'($urandom);
    for (int i = 0; i < last; i++) c = crc_byte(crc_byte(c, flash.mem[i][7:0]), flash.mem[i][15:8]);
    flash.mem[last] = good ? {c[7:0], c[15:8]} : ~{c[7:0], c[15:8]};
  endtask

  task automatic start(input logic [1:0] src, input bit good, input logic [7:0] ctl);
    load(last_of(src), good);
    wr(A_CFG, {6'h00, src});
    wr(A_CTRL, ctl);
    saw_stall = 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      check("early stall", {7'h00, stall | freq.rd}, 8'h00);
    end
  endtask

  task automatic finish(input bit good, input int last);
    wait_idle;
    check("status", rd_val[7:0], good ? 8'h02 : 8'h00);
    check("last word", freq.addr[7:0], 8'(last));
    check("stall seen", {7'h00, saw_stall}, 8'h01);
    check("stall freed", {7'h00, stall}, 8'h00);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  // Each scan is well under a thousand cycles; this bound only cuts a hang.
  initial begin
    #(4 * 40000);
    mismatches++;
    final_report;
  end

  initial begin
    logic [1:0] src;
    bit         good;
    reset = 1'b1;
    ahb = '0;
    boot = '0;
    ends = {16'h0003, 16'h0007, 16'h000b};
    {mismatches, samples_checked, cyc, last_rd} = '0;
    saw_stall = 1'b0;
    void'($urandom(32'h889c0092));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    expect_reg("control reset", A_CTRL, FCS_CTRL_RESET_VAL);
    expect_reg("config reset", A_CFG, FCS_CFG_RESET_VAL);
    expect_reg("status reset", A_STAT, FCS_STAT_RESET_VAL);
    expect_reg("unmapped", 32'h0000_0010, 8'h00);
    $display("test reset_values done");
    for (int s = 0; s < 4; s++) begin
      start(2'(s), 1'b1, 8'h01);
      finish(1'b1, last_of(2'(s)));
      expect_reg("enable kept", A_CTRL, 8'h01);
      expect_reg("section", A_CFG, {6'h00, 2'(s)});
    end
    for (int i = 0; i < 6; i++) begin
      src = 2'($urandom_range(2));
      good = 1'($urandom);
      start(src, good, 8'h01);
      finish(good, last_of(src));
    end
    check("no fatal", {7'h00, nmi}, 8'h00);
    $display("test sections done");
    start(FCS_SRC_FLASH, 1'b1, 8'h01);
    expect_reg("busy", A_STAT, {6'h00, good, 1'b1});
    wr(A_CTRL, 8'h02);
    expect_reg("ctrl while busy", A_CTRL, 8'h01);
    wr(A_CFG, 8'h02);
    expect_reg("cfg while busy", A_CFG, 8'h00);
    finish(1'b1, 11);
    start(FCS_SRC_BOOT, 1'b1, 8'h01);
    wr(A_CTRL, 8'h81);
    expect_reg("strobe ctrl", A_CTRL, 8'h00);
    expect_reg("strobe cfg", A_CFG, 8'h00);
    expect_reg("strobe status", A_STAT, FCS_STAT_RESET_VAL);
    $display("test busy_writes done");
    wr(A_CTRL, 8'h02);
    wr(A_CTRL, 8'h80);
    wr(A_CTRL, 8'h00);
    expect_reg("fatal enable kept", A_CTRL, 8'h02);
    start(FCS_SRC_BOOT, 1'b1, 8'h03);
    wr(A_CTRL, 8'h80);
    expect_reg("strobe refused", A_STAT, 8'h03);
    finish(1'b1, 3);
    start(FCS_SRC_LOADER_AND_PROGRAM_SECTIONS, 1'b0, 8'h03);
    finish(1'b0, 7);
    check("fatal raised", {7'h00, nmi}, 8'h01);
    wr(A_CTRL, 8'h80);
    wr(A_CFG, 8'h02);
    expect_reg("ctrl locked", A_CTRL, 8'h03);
    expect_reg("cfg locked", A_CFG, 8'h01);
    check("fatal held", {7'h00, nmi}, 8'h01);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check("fatal cleared", {7'h00, nmi}, 8'h00);
    expect_reg("ctrl after reset", A_CTRL, 8'h00);
    $display("test fatal done");
    load(3, 1'b1);
    boot <= '{req: 1'b1, mode: 2'h1, section: FCS_SRC_BOOT};
    @(posedge core_clk);
    boot <= '0;
    wait_idle;
    check("startup status", rd_val[7:0], 8'h02);
    expect_reg("startup enable", A_CTRL, 8'h01);
    expect_reg("startup cfg", A_CFG, 8'h12);
    wr(A_CFG, 8'h02);
    expect_reg("mode restored", A_CFG, 8'h02);
    $display("test startup done");
    final_report;
  end
endmodule
